//--- dsos_host.sv
// host controller that drives the one-shot and separates its gated pulses
`timescale 1ns/1ns
module dsos_host
  import dsos_pkg::*;
(
  input  wire logic        i_clock,
  input  wire logic        i_reset,
  input  wire logic        i_pulse_req,
  input  wire logic [1:0]  i_range_code,
  input  wire logic [15:0] i_low_period_ns,
  input  wire dsos_win_t   i_win,
  output logic             o_shaper_pulse,
  output logic [1:0]       o_range_code,
  output logic [15:0]      o_delay_ns,
  output dsos_sep_t        o_sep,
  output logic             o_busy
);

  // ****************************************
  // window pin synchroniser
  // ****************************************
  dsos_win_t win_s1_r;
  dsos_win_t win_s1_nxt;
  dsos_win_t win_s2_r;
  dsos_win_t win_s2_nxt;
  logic      win_prev_r;
  logic      win_prev_nxt;

  // two flops before any logic sees the pins
  always_comb begin
    win_s1_nxt   = i_win;
    win_s2_nxt   = win_s1_r;
    win_prev_nxt = win_s2_r.win_true;
  end

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      win_s1_r   <= '{win_true: 1'b0, win_inv: 1'b1};
      win_s2_r   <= '{win_true: 1'b0, win_inv: 1'b1};
      win_prev_r <= 1'b0;
    end else begin
      win_s1_r   <= win_s1_nxt;
      win_s2_r   <= win_s2_nxt;
      win_prev_r <= win_prev_nxt;
    end
  end

  // ****************************************
  // range and delay setting
  // ****************************************
  logic [1:0]  range_r;
  logic [1:0]  range_nxt;
  logic [15:0] delay_r;
  logic [15:0] delay_nxt;
  logic [17:0] three_q;
  logic [15:0] rmin;
  logic [15:0] rmax;

  // three quarters of the low-frequency period, clamped into the range
  always_comb begin
    range_nxt = i_range_code;
    three_q   = ({2'b00, i_low_period_ns} * 18'd3) >> 2;
    case (i_range_code)
      2'h0: begin
        rmin = RANGE_MIN_NS_0;
        rmax = RANGE_MAX_NS_0;
      end
      2'h1: begin
        rmin = RANGE_MIN_NS_1;
        rmax = RANGE_MAX_NS_1;
      end
      2'h2: begin
        rmin = RANGE_MIN_NS_2;
        rmax = RANGE_MAX_NS_2;
      end
      default: begin
        rmin = RANGE_MIN_NS_3;
        rmax = RANGE_MAX_NS_3;
      end
    endcase
    if (three_q < {2'b00, rmin}) begin
      delay_nxt = rmin;
    end else if (three_q > {2'b00, rmax}) begin
      delay_nxt = rmax;
    end else begin
      delay_nxt = three_q[15:0];
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      range_r <= RANGE_RST;
      delay_r <= DELAY_RST;
    end else begin
      range_r <= range_nxt;
      delay_r <= delay_nxt;
    end
  end

  // ****************************************
  // pulse generator with recycle guard
  // ****************************************
  dsos_state_t state_r;
  dsos_state_t state_nxt;
  logic [3:0]  wid_r;
  logic [3:0]  wid_nxt;
  logic [3:0]  guard_r;
  logic [3:0]  guard_nxt;
  logic        pulse_r;
  logic        pulse_nxt;
  logic        busy_r;
  logic        busy_nxt;
  logic [3:0]  recycle_cyc;
  logic        win_fall;

  // recycle count for the selected range, and the falling edge of the synchronised window
  always_comb begin
    case (range_r)
      2'h0:    recycle_cyc = RECYCLE_CYC_0;
      2'h1:    recycle_cyc = RECYCLE_CYC_1;
      2'h2:    recycle_cyc = RECYCLE_CYC_2;
      default: recycle_cyc = RECYCLE_CYC_3;
    endcase
    win_fall = win_prev_r & ~win_s2_r.win_true;
  end

  // a trailing edge only leaves after min width, window end and recycle
  always_comb begin
    state_nxt = state_r;
    wid_nxt   = wid_r;
    guard_nxt = guard_r;
    if (win_fall) begin
      guard_nxt = recycle_cyc;
    end else if (guard_r != 4'h0) begin
      guard_nxt = guard_r - 4'h1;
    end
    case (state_r)
      DSOS_IDLE: begin
        if (i_pulse_req) begin
          state_nxt = DSOS_HIGH;
          wid_nxt   = 4'(PULSE_CYC);
        end
      end
      DSOS_HIGH: begin
        if (wid_r > 4'h1) begin
          wid_nxt = wid_r - 4'h1;
        end else begin
          state_nxt = DSOS_HOLD;
        end
      end
      DSOS_HOLD: begin
        // hold the pulse high while a window runs or recycle is pending
        if (!win_s2_r.win_true && !win_fall && guard_r == 4'h0) begin
          state_nxt = DSOS_IDLE;
        end
      end
      default: begin
        state_nxt = DSOS_IDLE;
      end
    endcase
    pulse_nxt = (state_nxt != DSOS_IDLE);
    busy_nxt  = (state_nxt != DSOS_IDLE);
  end

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      state_r <= DSOS_IDLE;
      wid_r   <= 4'h0;
      guard_r <= 4'h0;
      pulse_r <= 1'b0;
      busy_r  <= 1'b0;
    end else begin
      state_r <= state_nxt;
      wid_r   <= wid_nxt;
      guard_r <= guard_nxt;
      pulse_r <= pulse_nxt;
      busy_r  <= busy_nxt;
    end
  end

  // ****************************************
  // separation gating
  // ****************************************
  logic [SYNC_STAGES-1:0] pdly_r;
  logic [SYNC_STAGES-1:0] pdly_nxt;
  dsos_sep_t              sep_r;
  dsos_sep_t              sep_nxt;

  // pulse stream delayed to match the window synchroniser, then gated
  always_comb begin
    pdly_nxt           = {pdly_r[SYNC_STAGES-2:0], pulse_r};
    sep_nxt.data_one   = pdly_r[SYNC_STAGES-1] & win_s2_r.win_true;
    sep_nxt.clk_pulse  = pdly_r[SYNC_STAGES-1] & win_s2_r.win_inv;
  end

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      pdly_r <= '0;
      sep_r  <= '0;
    end else begin
      pdly_r <= pdly_nxt;
      sep_r  <= sep_nxt;
    end
  end

  assign o_shaper_pulse = pulse_r;
  assign o_range_code   = range_r;
  assign o_delay_ns     = delay_r;
  assign o_sep          = sep_r;
  assign o_busy         = busy_r;

endmodule

//--- dsos_pkg.sv
// constants and carrier types for the data separator one-shot host controller
package dsos_pkg;

  // ****************************************
  // clock and timing
  // ****************************************
  localparam int unsigned CLK_PERIOD_NS  = 100;
  localparam int unsigned PULSE_MIN_NS   = 50;
  localparam int unsigned PULSE_CYC      = (PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SYNC_STAGES    = 2;

  // minimum recycle times per range code, nanoseconds
  localparam int unsigned RECYCLE_NS_0   = 80;
  localparam int unsigned RECYCLE_NS_1   = 100;
  localparam int unsigned RECYCLE_NS_2   = 130;
  localparam int unsigned RECYCLE_NS_3   = 310;

  // least times round up to whole cycles
  localparam logic [3:0] RECYCLE_CYC_0 =
    4'((RECYCLE_NS_0 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [3:0] RECYCLE_CYC_1 =
    4'((RECYCLE_NS_1 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [3:0] RECYCLE_CYC_2 =
    4'((RECYCLE_NS_2 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [3:0] RECYCLE_CYC_3 =
    4'((RECYCLE_NS_3 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // ****************************************
  // delay ranges per range code, nanoseconds
  // ****************************************
  localparam logic [15:0] RANGE_MIN_NS_0 = 16'd190;
  localparam logic [15:0] RANGE_MAX_NS_0 = 16'd450;
  localparam logic [15:0] RANGE_MIN_NS_1 = 16'd450;
  localparam logic [15:0] RANGE_MAX_NS_1 = 16'd1200;
  localparam logic [15:0] RANGE_MIN_NS_2 = 16'd1000;
  localparam logic [15:0] RANGE_MAX_NS_2 = 16'd3500;
  localparam logic [15:0] RANGE_MIN_NS_3 = 16'd1300;
  localparam logic [15:0] RANGE_MAX_NS_3 = 16'd4000;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [1:0]  RANGE_RST      = 2'h0;
  localparam logic [15:0] DELAY_RST      = 16'h00be;

  // ****************************************
  // carrier types
  // ****************************************
  typedef struct packed {
    logic win_true;  // window true output, high during window
    logic win_inv;   // window inverted output, low during window
  } dsos_win_t;

  typedef struct packed {
    logic data_one;  // pulse that fell inside the window
    logic clk_pulse; // pulse that fell outside the window
  } dsos_sep_t;

  typedef enum logic [1:0] {
    DSOS_IDLE,
    DSOS_HIGH,
    DSOS_HOLD
  } dsos_state_t;

endpackage

//--- dsos_chk.sv
// assertion checker for the one-shot host controller
`timescale 1ns/1ns
module dsos_chk
  import dsos_pkg::*;
(
  input wire logic        i_clock,
  input wire logic        i_reset,
  input wire logic        i_pulse_req,
  input wire logic [1:0]  i_range_code,
  input wire logic [15:0] i_low_period_ns,
  input wire dsos_win_t   i_win,
  input wire logic        o_shaper_pulse,
  input wire logic [1:0]  o_range_code,
  input wire logic [15:0] o_delay_ns,
  input wire dsos_sep_t   o_sep,
  input wire logic        o_busy
);
  // ************
  // port checks
  // ************
  default clocking @(posedge i_clock);
  endclocking
  default disable iff (i_reset);
  // request, pulse, busy and range code
  start_req_a: assert property (!i_reset && !o_busy && i_pulse_req |=> o_busy)
    else $error("request not taken");
  stay_idle_a: assert property (!i_reset && !o_busy && !i_pulse_req |=> !o_busy)
    else $error("busy without request");
  pulse_busy_a: assert property (o_shaper_pulse == o_busy)
    else $error("pulse and busy differ");
  range_copy_a: assert property (!i_reset |=> o_range_code == $past(i_range_code))
    else $error("range code not copied");
  // gating of pulses against the window
  data_gate_a: assert property (
    o_sep.data_one == ($past(o_shaper_pulse, 3) & $past(i_win.win_true, 3)))
    else $error("data pulse wrong");
  clock_gate_a: assert property (
    o_sep.clk_pulse == ($past(o_shaper_pulse, 3) & $past(i_win.win_inv, 3)))
    else $error("clock pulse wrong");
  // trailing edge kept out of the window and its recycle time
  window_hold_a: assert property (
    o_shaper_pulse && i_win.win_true && $past(i_win.win_true, 2) |=> o_shaper_pulse)
    else $error("pulse fell inside window");
  recycle_guard_a: assert property (
    $fell(i_win.win_true) && o_shaper_pulse |=> o_shaper_pulse [*2])
    else $error("recycle time cut short");
  cover property (o_sep.data_one);
  cover property (o_sep.clk_pulse);
  cover property (o_busy && i_pulse_req);
endmodule

bind dsos_host dsos_chk u_dsos_chk (.i_clock(i_clock), .i_reset(i_reset),
  .i_pulse_req(i_pulse_req), .i_range_code(i_range_code), .i_low_period_ns(i_low_period_ns),
  .i_win(i_win), .o_shaper_pulse(o_shaper_pulse), .o_range_code(o_range_code),
  .o_delay_ns(o_delay_ns), .o_sep(o_sep), .o_busy(o_busy));

//--- dsos_dev.sv
// behavioural model of the adjustable one-shot window device
`timescale 1ns/1ns
module dsos_dev
  import dsos_pkg::*;
(
  input  wire logic        i_pulse,
  input  wire logic [15:0] i_delay_ns,
  output dsos_win_t        o_win
);
  // ************
  // delay window
  // ************
  int lag = 5;
  // input stage delay, keeps window edges off the host clock edges
  localparam int PROP_NS = 3;
  // idle outputs
  initial o_win = 2'b01;
  // a trailing edge opens one full window; edges inside it are lost
  always begin
    wait (i_pulse === 1'b1);
    @(negedge i_pulse);
    #(PROP_NS);
    lag = 5 + i_delay_ns / 45;
    o_win.win_true = 1'b1;
    #(lag) o_win.win_inv = 1'b0;
    #(i_delay_ns - lag) o_win.win_true = 1'b0;
    #(lag) o_win.win_inv = 1'b1;
  end
endmodule

//--- test_data_separator_one_shot.sv
// self-checking bench for the one-shot host controller
`timescale 1ns/1ns
module test_data_separator_one_shot
  import dsos_pkg::*;
;
  // ************
  // bench
  // ************
  logic        i_clock   = 1'b0;
  logic        i_reset   = 1'b1;
  logic        req       = 1'b0;
  logic [1:0]  rng       = 2'h0;
  logic [15:0] per       = 16'h0190;
  logic [1:0]  rc_o;
  logic [15:0] dly_o;
  logic        pls;
  logic        busy;
  dsos_win_t   win;
  dsos_sep_t   sep;
  int          bad_count = 0;
  int          checks    = 0;
  int          n;
  int          d1;
  int          ck;
  // period and expected delay; range code is the row index halved
  logic [31:0] rows [8] = '{32'h0190_012c, 32'h0064_00be, 32'h07d0_04b0, 32'h0190_01c2,
                            32'h0fa0_0bb8, 32'h03e8_03e8, 32'h4000_0fa0, 32'h03e8_0514};
  dsos_host u_dsos_host (.i_clock(i_clock), .i_reset(i_reset), .i_pulse_req(req),
    .i_range_code(rng), .i_low_period_ns(per), .i_win(win), .o_shaper_pulse(pls),
    .o_range_code(rc_o), .o_delay_ns(dly_o), .o_sep(sep), .o_busy(busy));
  dsos_dev u_dsos_dev (.i_pulse(pls), .i_delay_ns(dly_o), .o_win(win));
  // clock
  always #50 i_clock = ~i_clock;
  // compare and count
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic wait_idle();
    for (n = 0; n < 300 && busy !== 1'b0; n++) @(negedge i_clock);
    if (n == 300) begin
      bad_count++;
      conclude();
    end
  endtask
  // reset, delay table, pulse runs per range, reset in mid-run
  initial begin
    repeat (9) @(posedge i_clock);
    @(negedge i_clock);
    chk(16'({pls, busy, sep, rc_o}), 16'h0);
    chk(dly_o, DELAY_RST);
    @(posedge i_clock);
    i_reset <= 1'b0;
    for (int k = 0; k < 8; k++) begin
      @(posedge i_clock);
      rng <= 2'(k >> 1);
      per <= rows[k][31:16];
      repeat (2) @(posedge i_clock);
      @(negedge i_clock);
      chk(dly_o, rows[k][15:0]);
      chk(16'(rc_o), 16'(k >> 1));
    end
    for (int r = 0; r < 4; r++) begin
      @(posedge i_clock);
      rng <= 2'(r);
      per <= (r > 1) ? 16'h07d0 : 16'(16'h0190 << r);
      req <= 1'b1;
      d1 = 0;
      ck = 0;
      repeat (150) begin
        @(negedge i_clock);
        d1 += int'(sep.data_one);
        ck += int'(sep.clk_pulse);
        chk(16'(sep.data_one & sep.clk_pulse), 16'h0);
      end
      @(posedge i_clock);
      req <= 1'b0;
      wait_idle();
      chk(16'(d1 > 0 && ck > 0), 16'h1);
    end
    @(posedge i_clock);
    req <= 1'b1;
    repeat (3) @(posedge i_clock);
    i_reset <= 1'b1;
    repeat (4) @(posedge i_clock);
    @(negedge i_clock);
    chk(16'({pls, busy, sep, rc_o}), 16'h0);
    @(posedge i_clock);
    i_reset <= 1'b0;
    repeat (2) @(posedge i_clock);
    @(negedge i_clock);
    chk(16'(busy), 16'h1);
    @(posedge i_clock);
    req <= 1'b0;
    wait_idle();
    conclude();
  end
endmodule
